// [rtl/aesc_pkg.sv]
package aesc_pkg;

    // buffer map, byte addresses
    localparam logic [15:0] AESC_KEY_BASE  = 16'h7c00;  // key buffer, 32 bytes
    localparam logic [15:0] AESC_TEXT_BUFFER_A     = 16'h7c20;  // text buffer a, 16 bytes
    localparam logic [15:0] AESC_TEXT_BUFFER_B     = 16'h7c30;  // text buffer b, 16 bytes
    localparam logic [15:0] AESC_XOR_RESULT_BUFFER    = 16'h7c40;  // xor result buffer, 16 bytes
    localparam logic [15:0] AESC_KEY_LEN   = 16'h0020;  // key buffer length
    localparam logic [15:0] AESC_TEXT_LEN  = 16'h0010;  // text buffer length

    // key size select codes
    localparam logic [1:0]  AESC_KS_128    = 2'h0;
    localparam logic [1:0]  AESC_KS_192    = 2'h1;
    localparam logic [3:0]  AESC_NK_128    = 4'h4;      // key words per key size
    localparam logic [3:0]  AESC_NK_192    = 4'h6;
    localparam logic [3:0]  AESC_NK_256    = 4'h8;
    localparam logic [3:0]  AESC_NR_EXTRA  = 4'h6;      // rounds = key words + 6
    localparam int          AESC_KS_DEPTH  = 64;        // roundkey word store depth

    // field constants of the cipher
    localparam logic [7:0]  AESC_POLY      = 8'h1b;
    localparam logic [7:0]  AESC_AFFINE    = 8'h63;
    localparam logic [7:0]  AESC_INV_AFF   = 8'h05;
    localparam logic [7:0]  AESC_RCON0     = 8'h01;
    localparam logic [2:0]  AESC_SUBW_POS  = 3'h4;      // extra subword slot, 256-bit keys

    // operation codes
    typedef enum logic [1:0] {
        AESC_OP_ENCRYPT = 2'h0,
        AESC_OP_CHAIN   = 2'h1,
        AESC_OP_DECRYPT = 2'h2
    } aesc_op_t;

    // engine states, gray along idle-expand-pre-round
    typedef enum logic [1:0] {
        AESC_IDLE   = 2'h0,
        AESC_EXPAND = 2'h1,
        AESC_PRE    = 2'h3,
        AESC_ROUND  = 2'h2
    } aesc_state_t;

    // byte-wide buffer access port
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } aesc_bus_req_t;

    // control bits from the control registers
    typedef struct packed {
        logic        cipher_start_set;
        logic [1:0]  cipher_operation_select;
        logic [1:0]  key_size_select;
    } aesc_ctrl_t;

    // address falls in a buffer
    function automatic logic in_buf(input logic [15:0] a, input logic [15:0] base,
                                    input logic [15:0] len);
        return (a >= base) && (a < base + len);
    endfunction : in_buf

    // key words for a key size
    function automatic logic [3:0] nk_of(input logic [1:0] ks);
        return (ks == AESC_KS_128) ? AESC_NK_128 :
               (ks == AESC_KS_192) ? AESC_NK_192 : AESC_NK_256;
    endfunction : nk_of

    function automatic logic [7:0] xtime(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? AESC_POLY : 8'h00);
    endfunction : xtime

    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = '0;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) p = p ^ x;
            x = xtime(x);
        end
        return p;
    endfunction : gmul

    // field inverse as a^254, zero maps to zero
    function automatic logic [7:0] ginv(input logic [7:0] a);
        logic [7:0] r;
        logic [7:0] p;
        r = AESC_RCON0;
        p = a;
        for (int i = 1; i < 8; i++) begin
            p = gmul(p, p);
            r = gmul(r, p);
        end
        return r;
    endfunction : ginv

    function automatic logic [7:0] rotl8(input logic [7:0] b, input int n);
        logic [15:0] d;
        d = {b, b} << n;
        return d[15:8];
    endfunction : rotl8

    // forward or inverse substitution of one byte
    function automatic logic [7:0] sbox(input logic [7:0] a, input logic inv);
        logic [7:0] b;
        b = ginv(a);
        if (inv) return ginv(rotl8(a, 1) ^ rotl8(a, 3) ^ rotl8(a, 6) ^ AESC_INV_AFF);
        return b ^ rotl8(b, 1) ^ rotl8(b, 2) ^ rotl8(b, 3) ^ rotl8(b, 4) ^ AESC_AFFINE;
    endfunction : sbox

    function automatic logic [31:0] sub_word(input logic [31:0] w);
        logic [31:0] o;
        for (int i = 0; i < 4; i++) o[8*i +: 8] = sbox(w[8*i +: 8], 1'b0);
        return o;
    endfunction : sub_word

    function automatic logic [127:0] sub_bytes(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        for (int i = 0; i < 16; i++) o[8*i +: 8] = sbox(s[8*i +: 8], inv);
        return o;
    endfunction : sub_bytes

    // byte 4c+r of the state sits at the top for byte 0
    function automatic logic [127:0] shift_rows(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        int src;
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++) begin
                src = inv ? 4*((c - r + 4) % 4) + r : 4*((c + r) % 4) + r;
                o[8*(15-(4*c+r)) +: 8] = s[8*(15-src) +: 8];
            end
        return o;
    endfunction : shift_rows

    function automatic logic [127:0] mix_columns(input logic [127:0] s, input logic inv);
        logic [127:0] o;
        logic [31:0]  cf;
        cf = inv ? 32'h0e0b_0d09 : 32'h0203_0101;
        o = '0;
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
                for (int k = 0; k < 4; k++)
                    o[8*(15-(4*c+r)) +: 8] = o[8*(15-(4*c+r)) +: 8] ^
                        gmul(s[8*(15-(4*c+(r+k)%4)) +: 8], cf[8*(3-k) +: 8]);
        return o;
    endfunction : mix_columns

endpackage : aesc_pkg

// [rtl/aesc_rk_mem.sv]
`timescale 1ns/1ps
`default_nettype none

module aesc_rk_mem (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset,
    // word write side
    input  wire logic         wr_en,
    input  wire logic [5:0]   wr_addr,
    input  wire logic [31:0]  wr_data,
    // roundkey read side
    input  wire logic [3:0]   rd_idx,
    output logic      [127:0] rd_data
);
    import aesc_pkg::*;

    logic [31:0]  mem [AESC_KS_DEPTH];   // expanded key words
    logic [127:0] rd_nxt;                // four words of one roundkey

    // gather the four words of the addressed roundkey
    always_comb begin
        rd_nxt = '0;
        for (int k = 0; k < 4; k++)
            rd_nxt[32*(3-k) +: 32] = mem[6'({rd_idx, 2'b00}) + 6'(k)];
    end

    // array write and registered read
    always_ff @(posedge core_clk) begin
        if (wr_en) mem[wr_addr] <= wr_data;
        if (reset) rd_data <= '0;
        else       rd_data <= rd_nxt;
    end

endmodule : aesc_rk_mem

`default_nettype wire

// [rtl/aesc_engine.sv]
// Summary of operation
// - whole 128-bit blocks only, no padding
// - key size 128, 192 or 256 bits
// - encryption expands key; decryption needs it first
// - start bit launches work, host clears it; busy drops when done
// - two-bit operation code selects the operation
// - code 00 encrypts text a in place
// - code 10 decrypts text a in place
// - code 01 encrypts a xor b into a
// - decrypt result xor b goes to xor buffer
// - feedback: encrypted a xor b into xor buffer
// - code 01 chains previous feedback ciphertext
// - only full 128-bit feedback width natively
`timescale 1ns/1ps
`default_nettype none

module aesc_engine (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    // buffer access port
    input  wire aesc_pkg::aesc_bus_req_t bus_req,
    output logic [7:0]                   bus_rdata,
    // control and status bits
    input  wire aesc_pkg::aesc_ctrl_t    ctrl,
    output logic                         cipher_start_busy
);
    import aesc_pkg::*;

    aesc_state_t  state_r,  state_nxt;    // engine sequencer
    logic [255:0] key_r,    key_nxt;      // key buffer, leftmost byte on top
    logic [127:0] text_a_r, text_a_nxt;   // text buffer a
    logic [127:0] text_b_r, text_b_nxt;   // text buffer b
    logic [127:0] xor_r,    xor_nxt;      // xor result buffer
    logic [127:0] in_r,     in_nxt;       // block input latched at start
    logic [127:0] s_r,      s_nxt;        // cipher state
    logic [31:0]  hist_r [8];             // last key words, newest first
    logic [31:0]  hist_nxt [8];
    logic [3:0]   nk_r,     nk_nxt;       // key words of current key
    logic         dec_r,    dec_nxt;      // running a decryption
    logic [5:0]   widx_r,   widx_nxt;     // key word being expanded
    logic [2:0]   modk_r,   modk_nxt;     // word index modulo key words
    logic [7:0]   rcon_r,   rcon_nxt;     // round constant
    logic [3:0]   rnd_r,    rnd_nxt;      // roundkey index in use
    logic [7:0]   rdata_nxt;              // next read data
    logic [3:0]   nr;                     // rounds of current key
    logic [5:0]   nw;                     // expanded words of current key
    logic [15:0]  off;                    // offset into addressed buffer
    logic         op_ok;                  // operation code is defined
    logic         start_acc;              // start taken this cycle
    logic         last_rnd;               // final round in this cycle
    logic         mem_we;                 // roundkey word write
    logic [31:0]  new_word;               // expanded word
    logic [31:0]  temp;                   // key schedule intermediate
    logic [127:0] round_out;              // state after this round
    logic [127:0] rk;                     // roundkey from the store

    assign nr        = nk_r + AESC_NR_EXTRA;
    assign nw        = {nr + 4'h1, 2'b00};
    assign op_ok     = ctrl.cipher_operation_select != 2'h3;
    assign start_acc = (state_r == AESC_IDLE) && ctrl.cipher_start_set && op_ok;
    assign last_rnd  = (state_r == AESC_ROUND) && (dec_r ? (rnd_r == 4'h0) : (rnd_r == nr));
    assign cipher_start_busy = (state_r != AESC_IDLE);

    // roundkey store, written during expansion, read per round
    aesc_rk_mem u_rk_mem (
        .core_clk (core_clk),
        .reset    (reset),
        .wr_en    (mem_we),
        .wr_addr  (widx_r),
        .wr_data  (new_word),
        .rd_idx   (rnd_nxt),
        .rd_data  (rk)
    );

    // next-state logic for buffers, key schedule and rounds
    always_comb begin
        state_nxt  = state_r;
        key_nxt    = key_r;
        text_a_nxt = text_a_r;
        text_b_nxt = text_b_r;
        xor_nxt    = xor_r;
        in_nxt     = in_r;
        s_nxt      = s_r;
        hist_nxt   = hist_r;
        nk_nxt     = nk_r;
        dec_nxt    = dec_r;
        widx_nxt   = widx_r;
        modk_nxt   = modk_r;
        rcon_nxt   = rcon_r;
        rnd_nxt    = rnd_r;
        rdata_nxt  = bus_rdata;
        mem_we     = 1'b0;
        new_word   = '0;
        temp       = '0;
        round_out  = '0;
        off        = '0;
        // byte writes; key and text a are locked while busy, b stays open
        if (bus_req.wr) begin
            if (in_buf(bus_req.addr, AESC_KEY_BASE, AESC_KEY_LEN)) begin
                off = bus_req.addr - AESC_KEY_BASE;
                if (state_r == AESC_IDLE) key_nxt[8*(31-off[4:0]) +: 8] = bus_req.wdata;
            end else if (in_buf(bus_req.addr, AESC_TEXT_BUFFER_A, AESC_TEXT_LEN)) begin
                off = bus_req.addr - AESC_TEXT_BUFFER_A;
                if (state_r == AESC_IDLE) text_a_nxt[8*(15-off[3:0]) +: 8] = bus_req.wdata;
            end else if (in_buf(bus_req.addr, AESC_TEXT_BUFFER_B, AESC_TEXT_LEN)) begin
                off = bus_req.addr - AESC_TEXT_BUFFER_B;
                text_b_nxt[8*(15-off[3:0]) +: 8] = bus_req.wdata;
            end
        end
        // byte reads, unmapped reads give zero
        if (bus_req.rd) begin
            rdata_nxt = '0;
            if (in_buf(bus_req.addr, AESC_KEY_BASE, AESC_KEY_LEN))
                rdata_nxt = key_r[8*(31-5'(bus_req.addr - AESC_KEY_BASE)) +: 8];
            else if (in_buf(bus_req.addr, AESC_TEXT_BUFFER_A, AESC_TEXT_LEN))
                rdata_nxt = text_a_r[8*(15-4'(bus_req.addr - AESC_TEXT_BUFFER_A)) +: 8];
            else if (in_buf(bus_req.addr, AESC_TEXT_BUFFER_B, AESC_TEXT_LEN))
                rdata_nxt = text_b_r[8*(15-4'(bus_req.addr - AESC_TEXT_BUFFER_B)) +: 8];
            else if (in_buf(bus_req.addr, AESC_XOR_RESULT_BUFFER, AESC_TEXT_LEN))
                rdata_nxt = xor_r[8*(15-4'(bus_req.addr - AESC_XOR_RESULT_BUFFER)) +: 8];
        end
        unique case (state_r)
            // wait for start; latch operation, key size and input block
            AESC_IDLE: begin
                if (start_acc) begin
                    nk_nxt   = nk_of(ctrl.key_size_select);
                    dec_nxt  = ctrl.cipher_operation_select == AESC_OP_DECRYPT;
                    // chain input a xor b equals the last feedback ciphertext
                    in_nxt   = (ctrl.cipher_operation_select == AESC_OP_CHAIN) ?
                               text_a_r ^ text_b_r : text_a_r;
                    widx_nxt = '0;
                    modk_nxt = '0;
                    rcon_nxt = AESC_RCON0;
                    // decryption reuses the schedule of the last encryption
                    state_nxt = dec_nxt ? AESC_PRE : AESC_EXPAND;
                    rnd_nxt   = dec_nxt ? nk_nxt + AESC_NR_EXTRA : 4'h0;
                end
            end
            // one key word per cycle into the roundkey store
            AESC_EXPAND: begin
                if (widx_r < 6'(nk_r)) begin
                    new_word = key_r[32*(7-widx_r[2:0]) +: 32];
                end else begin
                    if (modk_r == 3'h0)
                        temp = sub_word({hist_r[0][23:0], hist_r[0][31:24]}) ^ {rcon_r, 24'h0};
                    else if (nk_r == AESC_NK_256 && modk_r == AESC_SUBW_POS)
                        temp = sub_word(hist_r[0]);
                    else
                        temp = hist_r[0];
                    new_word = hist_r[3'(nk_r - 4'h1)] ^ temp;
                    if (modk_r == 3'h0) rcon_nxt = xtime(rcon_r);
                end
                mem_we      = 1'b1;
                hist_nxt[0] = new_word;
                for (int k = 1; k < 8; k++) hist_nxt[k] = hist_r[k-1];
                modk_nxt = (4'(modk_r) == nk_r - 4'h1) ? 3'h0 : modk_r + 3'h1;
                widx_nxt = widx_r + 6'h1;
                if (widx_r == nw - 6'h1) state_nxt = AESC_PRE;
            end
            // roundkey for the first round is being read
            AESC_PRE: begin
                state_nxt = AESC_ROUND;
            end
            // one full round per cycle
            AESC_ROUND: begin
                if (!dec_r) begin
                    if (rnd_r == 4'h0) round_out = in_r ^ rk;
                    else begin
                        round_out = shift_rows(sub_bytes(s_r, 1'b0), 1'b0);
                        if (rnd_r != nr) round_out = mix_columns(round_out, 1'b0);
                        round_out = round_out ^ rk;
                    end
                    rnd_nxt = rnd_r + 4'h1;
                end else begin
                    if (rnd_r == nr) round_out = in_r ^ rk;
                    else begin
                        round_out = sub_bytes(shift_rows(s_r, 1'b1), 1'b1) ^ rk;
                        if (rnd_r != 4'h0) round_out = mix_columns(round_out, 1'b1);
                    end
                    rnd_nxt = rnd_r - 4'h1;
                end
                s_nxt = round_out;
                if (last_rnd) begin
                    text_a_nxt = round_out;
                    xor_nxt    = round_out ^ text_b_r;
                    rnd_nxt    = rnd_r;
                    state_nxt  = AESC_IDLE;
                end
            end
        endcase
    end

    // register stage, synchronous reset
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r  <= AESC_IDLE;
            key_r    <= '0;
            text_a_r <= '0;
            text_b_r <= '0;
            xor_r    <= '0;
            in_r     <= '0;
            s_r      <= '0;
            for (int k = 0; k < 8; k++) hist_r[k] <= '0;
            nk_r      <= AESC_NK_128;
            dec_r     <= 1'b0;
            widx_r    <= '0;
            modk_r    <= '0;
            rcon_r    <= AESC_RCON0;
            rnd_r     <= '0;
            bus_rdata <= '0;
        end else begin
            state_r   <= state_nxt;
            key_r     <= key_nxt;
            text_a_r  <= text_a_nxt;
            text_b_r  <= text_b_nxt;
            xor_r     <= xor_nxt;
            in_r      <= in_nxt;
            s_r       <= s_nxt;
            hist_r    <= hist_nxt;
            nk_r      <= nk_nxt;
            dec_r     <= dec_nxt;
            widx_r    <= widx_nxt;
            modk_r    <= modk_nxt;
            rcon_r    <= rcon_nxt;
            rnd_r     <= rnd_nxt;
            bus_rdata <= rdata_nxt;
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence run_s;
        ##[13:77] !cipher_start_busy;
    endsequence

    // decryption goes straight to the roundkey read, then to the rounds
    sequence dec_path_s;
        state_r == AESC_PRE ##1 state_r == AESC_ROUND;
    endsequence

    busy_rise_a: assert property (start_acc |=> cipher_start_busy)
        else $error("start not reflected in busy");
    busy_done_a: assert property (start_acc |-> run_s)
        else $error("operation did not finish in time");
    busy_clear_a: assert property ($fell(cipher_start_busy) |-> $past(last_rnd))
        else $error("busy cleared without a final round");
    key_size_a: assert property (start_acc && ctrl.key_size_select == 2'h2 |=> nk_r == 4'h8)
        else $error("key size not taken");
    dec_skip_a: assert property (start_acc && ctrl.cipher_operation_select == 2'h2
                                 |=> dec_path_s)
        else $error("decryption did not skip expansion");
    chain_in_a: assert property (start_acc && ctrl.cipher_operation_select == 2'h1
                                 |=> in_r == ($past(text_a_r) ^ $past(text_b_r)))
        else $error("chain input not a xor b");
    result_a_a: assert property (last_rnd |=> text_a_r == $past(round_out))
        else $error("result not written to text a");
    xor_out_a: assert property (last_rnd
                                |=> xor_r == ($past(round_out) ^ $past(text_b_r)))
        else $error("xor buffer wrong");
    hold_buf_a: assert property (!cipher_start_busy && !bus_req.wr
                                 |=> $stable(text_a_r) && $stable(xor_r))
        else $error("idle buffers changed");

endmodule : aesc_engine

`default_nettype wire

// [testbench/aesc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module aesc_host_model (
    // clock and engine answers
    input  wire logic                   core_clk,
    input  wire logic [7:0]             bus_rdata,
    input  wire logic                   cipher_start_busy,
    // requests towards the engine
    output var  aesc_pkg::aesc_bus_req_t bus_req,
    output var  aesc_pkg::aesc_ctrl_t    ctrl
);
    import aesc_pkg::*;

    time t0;  // falling edge just after the taking edge

    // idle bus and control from time zero
    initial begin
        bus_req = '0;
        ctrl    = '0;
    end

    // one byte per cycle, n bytes from the top of v, msb at lowest address
    task automatic put(input logic [15:0] base, input logic [255:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            bus_req <= {base + 16'(i), 2'b10, v[255-8*i -: 8]};
        end
        @(negedge core_clk);
        bus_req.wr <= 1'b0;
    endtask : put

    // one byte per two cycles, data sampled after the answering edge
    task automatic get(input logic [15:0] base, output logic [127:0] v);
        for (int i = 0; i < 16; i++) begin
            @(negedge core_clk);
            bus_req <= {base + 16'(i), 2'b01, 8'h00};
            @(negedge core_clk);
            v[127-8*i -: 8] = bus_rdata;
        end
        bus_req.rd <= 1'b0;
    endtask : get

    // start only from idle, so key and context stay untouched mid-block
    task automatic run(input logic [1:0] op, input logic [1:0] ks);
        wait (cipher_start_busy === 1'b0);
        @(negedge core_clk);
        ctrl <= {1'b1, op, ks};
        @(negedge core_clk);
        ctrl.cipher_start_set <= 1'b0;
        t0 = $time;
    endtask : run

    // busy cycles counted from the taking edge, bounded wait
    task automatic done(output int n);
        for (int i = 0; i < 200 && cipher_start_busy !== 1'b0; i++) @(negedge core_clk);
        n = int'(($time - t0) / 5);
    endtask : done

endmodule : aesc_host_model

`default_nettype wire

// [testbench/test_aes_block_engine_control.sv]
`timescale 1ns/1ps
`default_nettype none

module test_aes_block_engine_control;
    import aesc_pkg::*;

    logic          core_clk = 1'b0;   // 200 mhz
    logic          reset    = 1'b1;   // synchronous, active high
    aesc_bus_req_t bus_req;           // buffer port from the host
    aesc_ctrl_t    ctrl;              // control bits from the host
    logic [7:0]    bus_rdata;         // read byte
    logic          cipher_start_busy; // start/busy bit
    int            err_count  = 0;
    int            num_checks = 0;
    // reference vectors: plaintext and its ciphertext per key size
    logic [127:0]  pt   = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
    logic [127:0]  ct [$] = '{128'h69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a,
                              128'hdda9_7ca4_864c_dfe0_6eaf_70a0_ec0d_7191,
                              128'h8ea2_b7ca_5167_45bf_eafc_4990_4b49_6089};

    always #2.5 core_clk = ~core_clk;

    aesc_engine u_dut (
        .core_clk          (core_clk),
        .reset             (reset),
        .bus_req           (bus_req),
        .bus_rdata         (bus_rdata),
        .ctrl              (ctrl),
        .cipher_start_busy (cipher_start_busy)
    );

    aesc_host_model u_host (
        .core_clk          (core_clk),
        .bus_rdata         (bus_rdata),
        .cipher_start_busy (cipher_start_busy),
        .bus_req           (bus_req),
        .ctrl              (ctrl)
    );

    // verdict and end of run
    task automatic wrap_up();
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    // one comparison, four-state exact
    task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] seen);
        num_checks++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask : chk

    // one block: m[1] keeps text a, m[0] writes text b after the start
    task automatic blk(input logic [1:0] op, ks, input logic [127:0] a, b,
                       input logic [1:0] m, input logic [127:0] ea, ex, input int en);
        logic [127:0] v;
        int           n;
        if (!m[1]) u_host.put(AESC_TEXT_BUFFER_A, {a, 128'h0}, 16);
        if (!m[0]) u_host.put(AESC_TEXT_BUFFER_B, {b, 128'h0}, 16);
        u_host.run(op, ks);
        if (m[0]) u_host.put(AESC_TEXT_BUFFER_B, {b, 128'h0}, 16);
        u_host.done(n);
        chk("busy_cycles", 128'(en), 128'(n));
        u_host.get(AESC_TEXT_BUFFER_A, v);
        chk("text_a", ea, v);
        u_host.get(AESC_XOR_RESULT_BUFFER, v);
        chk("xor_result", ex, v);
    endtask : blk

    // main sequence
    initial begin
        logic [255:0] key;
        logic [127:0] v;
        logic [127:0] r;
        int           n;
        void'($urandom(75));
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        reset <= 1'b0;
        u_host.get(AESC_TEXT_BUFFER_A, v);
        chk("reset_text_a", 128'h0, v);
        // every key size, left-aligned key, encrypt then decrypt
        for (int k = 0; k < 3; k++) begin
            r = {$urandom, $urandom, $urandom, $urandom};
            for (int i = 0; i < 32; i++) key[255-8*i -: 8] = (i < 16 + 8*k) ? 8'(i) : 8'h00;
            u_host.put(AESC_KEY_BASE, key, 32);
            blk(2'h0, 2'(k), pt, r, 2'h0, ct[k], ct[k] ^ r, 5*(11+2*k)+1);
            blk(2'h2, 2'(k), ct[k], r, 2'h0, pt, pt ^ r, 12+2*k);
        end
        // chained encryption: a xor b goes through the cipher
        r = {$urandom, $urandom, $urandom, $urandom};
        blk(2'h1, 2'h2, r, pt ^ r, 2'h0, ct[2], ct[2] ^ pt ^ r, 76);
        // feedback: b after start, then the xor buffer feeds the next block
        blk(2'h0, 2'h2, pt, ct[2] ^ pt, 2'h1, ct[2], pt, 76);
        blk(2'h1, 2'h2, 128'h0, r, 2'h3, ct[2], ct[2] ^ r, 76);
        // chained decryption: previous ciphertext copied into b as chaining value
        blk(2'h2, 2'h2, ct[2], ct[2], 2'h0, pt, pt ^ ct[2], 16);
        // feedback encryption: plaintext in a, random value written to b after start
        blk(2'h0, 2'h2, pt, r, 2'h1, ct[2], ct[2] ^ r, 76);
        // context save: key reads back whole for a later resume
        u_host.get(AESC_KEY_BASE, v);
        chk("key_saved_hi", key[255:128], v);
        u_host.get(AESC_KEY_BASE + AESC_TEXT_LEN, v);
        chk("key_saved_lo", key[127:0], v);
        // refused operation code leaves the engine idle
        u_host.run(2'h3, 2'h0);
        u_host.done(n);
        chk("op_refused", 128'h0, 128'(n));
        // xor buffer is read only, unmapped reads give zero
        u_host.put(AESC_XOR_RESULT_BUFFER, {pt, 128'h0}, 16);
        u_host.get(AESC_XOR_RESULT_BUFFER, v);
        chk("xor_read_only", ct[2] ^ r, v);
        u_host.get(16'h7c50, v);
        chk("unmapped_read", 128'h0, v);
        wrap_up();
    end

    // watchdog against a hung handshake
    initial begin
        #100_000;
        err_count++;
        wrap_up();
    end

endmodule : test_aes_block_engine_control

`default_nettype wire
